/* File: common/prde_pkg.sv */
// Purpose: shared constants and types for the plot/raster draw engine
// Assumes: 16-bit coordinates, 32-bit AXI4-Lite register words
// Notes: offsets are byte addresses
package prde_pkg;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_COLOR = 8'h08;
    localparam logic [7:0] OFF_START = 8'h0C;
    localparam logic [7:0] OFF_BASELINE = 8'h10;
    localparam logic [7:0] OFF_DIM = 8'h14;
    localparam logic [7:0] OFF_SPACING = 8'h18;
    localparam logic [7:0] OFF_WIN_MIN = 8'h1C;
    localparam logic [7:0] OFF_WIN_MAX = 8'h20;
    localparam logic [7:0] OFF_INDEX1 = 8'h24;
    localparam logic [7:0] OFF_INDEX2 = 8'h28;
    localparam logic [7:0] OFF_COUNT = 8'h2C;
    localparam logic [7:0] OFF_OPPOINT = 8'h30;
    // ctrl fields
    localparam int CTRL_GO = 0;
    localparam int CTRL_RASTER = 1;
    localparam int CTRL_BK = 2;
    localparam int CTRL_NOWR = 3;
    localparam int CTRL_ORDER = 4;
    localparam int CTRL_USE_START = 5;
    localparam int CTRL_SCAN_LO = 8;
    localparam int CTRL_IX_LO = 12;
    localparam int CTRL_SCALE_LO = 14;
    localparam logic [2:0] SCAN_HORIZ = 3'h0;
    localparam logic [2:0] SCAN_VERT = 3'h4;
    localparam logic [1:0] IX_OFS1 = 2'h1;
    localparam logic [1:0] IX_OFS2 = 2'h2;
    localparam logic [1:0] SCALE_HALF = 2'h1;
    localparam logic [1:0] SCALE_QUARTER = 2'h2;
    localparam logic [31:0] RST_WORD = 32'h00000000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {PRDE_IDLE, PRDE_FETCH, PRDE_SEG, PRDE_RFETCH, PRDE_RPIX} prde_state_t;
endpackage

/* File: src/prde_engine.sv */
// Purpose: plot and raster drawing engine writing pixels to refresh memory
// Assumes: host data words arrive on a valid/ready stream, memory takes one pixel per cycle
// Notes: parameters are set over AXI4-Lite; a write of ctrl with go starts an instruction
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module prde_engine
    import prde_pkg::*;
(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // axi4-lite write
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // axi4-lite read
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // host data stream
    input wire logic [15:0] i_data,
    input wire logic i_data_valid,
    output logic o_data_ready,
    // refresh memory write port
    output logic o_pix_we,
    output logic [15:0] o_pix_x,
    output logic [15:0] o_pix_y,
    output logic [7:0] o_pix_value,
    output logic [7:0] o_pix_mask,
    output logic o_busy
);
    ////////////////////////////////////////////////////////////////
    logic [31:0] ctrl, color, start, baseline, dim, spacing, win_min, win_max, index1, index2, count;
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic go_pulse;
    prde_state_t state;
    logic [15:0] cop_x, cop_y;
    logic [15:0] bytes_left;
    logic [15:0] word_buf;
    logic second_half;
    logic [7:0] cur_byte;
    logic [2:0] bit_idx;
    logic [15:0] seg_a, seg_b, seg_lo, seg_hi, seg_u, seg_v, seg_len;
    logic [15:0] px, py;

    wire [2:0] scan = ctrl[CTRL_SCAN_LO +: 3];
    wire [1:0] ix = ctrl[CTRL_IX_LO +: 2];
    wire [1:0] scale = ctrl[CTRL_SCALE_LO +: 2];
    wire vert = (scan == SCAN_VERT);
    wire bk = ctrl[CTRL_BK];
    wire [7:0] fg = color[7:0];
    wire [7:0] bg = color[15:8];
    wire [7:0] submask = color[23:16];

    // index displacement: offset two is itself displaced by offset one under mode 01
    wire [15:0] ofs_x = (ix == IX_OFS1) ? index1[15:0] : (ix == IX_OFS2) ? index2[15:0] : 16'h0000;
    wire [15:0] ofs_y = (ix == IX_OFS1) ? index1[31:16] : (ix == IX_OFS2) ? index2[31:16] : 16'h0000;
    wire [15:0] bl_raw = baseline[15:0];
    wire bl_on = (bl_raw != 16'h0000);
    wire [15:0] bl_abs = bl_raw + (vert ? ofs_x : ofs_y);
    wire [15:0] st_x = start[15:0] + ofs_x;
    wire [15:0] st_y = start[31:16] + ofs_y;
    wire [15:0] wx0 = win_min[15:0] + ofs_x;
    wire [15:0] wy0 = win_min[31:16] + ofs_y;
    wire [15:0] wx1 = win_max[15:0] + ofs_x;
    wire [15:0] wy1 = win_max[31:16] + ofs_y;

    ////////////////////////////////////////////////////////////////
    // register bus
    wire do_write = aw_held && w_held && !o_bvalid;
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= RST_WORD;
            w_strb <= 4'h0;
            o_bvalid <= 1'b0;
            o_bresp <= RESP_OKAY;
            o_awready <= 1'b0;
            o_wready <= 1'b0;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_held <= 1'b1;
                aw_addr <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_held <= 1'b1;
                w_data <= i_wdata;
                w_strb <= i_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= (aw_addr <= OFF_COUNT && aw_addr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
            // ready tracks the next state of each holding slot, so the port comes straight from a flop
            o_awready <= do_write || !(aw_held || (i_awvalid && o_awready));
            o_wready <= do_write || !(w_held || (i_wvalid && o_wready));
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // parameter registers are not written while an instruction runs
    wire wr_ok = do_write && (state == PRDE_IDLE);
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ctrl <= RST_WORD; color <= RST_WORD; start <= RST_WORD; baseline <= RST_WORD;
            dim <= RST_WORD; spacing <= RST_WORD; win_min <= RST_WORD; win_max <= RST_WORD;
            index1 <= RST_WORD; index2 <= RST_WORD; count <= RST_WORD;
            go_pulse <= 1'b0;
        end else begin
            go_pulse <= 1'b0;
            if (wr_ok) begin
                case (aw_addr)
                    OFF_CTRL: begin
                        ctrl <= merge(ctrl, w_data, w_strb) & 32'hFFFFFFFE;
                        go_pulse <= w_strb[0] & w_data[CTRL_GO];
                    end
                    OFF_COLOR: color <= merge(color, w_data, w_strb);
                    OFF_START: start <= merge(start, w_data, w_strb);
                    OFF_BASELINE: baseline <= merge(baseline, w_data, w_strb);
                    OFF_DIM: dim <= merge(dim, w_data, w_strb);
                    OFF_SPACING: spacing <= merge(spacing, w_data, w_strb);
                    OFF_WIN_MIN: win_min <= merge(win_min, w_data, w_strb);
                    OFF_WIN_MAX: win_max <= merge(win_max, w_data, w_strb);
                    OFF_INDEX1: index1 <= merge(index1, w_data, w_strb);
                    // index two set alongside index one mode is displaced by index one
                    OFF_INDEX2: index2 <= (ix == IX_OFS1) ? {w_data[31:16] + index1[31:16], w_data[15:0] + index1[15:0]}
                                                          : merge(index2, w_data, w_strb);
                    OFF_COUNT: count <= merge(count, w_data, w_strb);
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= RST_WORD;
            o_rresp <= RESP_OKAY;
        end else begin
            o_arready <= !o_rvalid && !o_arready;
            if (i_arvalid && o_arready) begin
                o_rvalid <= 1'b1;
                o_rresp <= RESP_OKAY;
                case (i_araddr)
                    OFF_CTRL: o_rdata <= ctrl;
                    OFF_STATUS: o_rdata <= {15'h0000, bytes_left, (state != PRDE_IDLE)};
                    OFF_COLOR: o_rdata <= color;
                    OFF_START: o_rdata <= start;
                    OFF_BASELINE: o_rdata <= baseline;
                    OFF_DIM: o_rdata <= dim;
                    OFF_SPACING: o_rdata <= spacing;
                    OFF_WIN_MIN: o_rdata <= win_min;
                    OFF_WIN_MAX: o_rdata <= win_max;
                    OFF_INDEX1: o_rdata <= index1;
                    OFF_INDEX2: o_rdata <= index2;
                    OFF_COUNT: o_rdata <= count;
                    OFF_OPPOINT: o_rdata <= {cop_y, cop_x};
                    default: begin
                        o_rdata <= RST_WORD;
                        o_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // raster bit selection
    function automatic logic bit_used(input logic [2:0] b, input logic [1:0] s);
        if (s == SCALE_HALF) begin
            return b[0];
        end else if (s == SCALE_QUARTER) begin
            return b[1:0] == 2'h3;
        end
        return 1'b1;
    endfunction

    wire bit_val = cur_byte[bit_idx];
    wire at_prim_end = vert ? (py == wy1) : (px == wx1);
    wire at_sec_end = vert ? (px == wx1) : (py == wy1);
    wire byte_done = (bit_idx == 3'h0) || at_prim_end;
    wire [15:0] data_abs = i_data + (vert ? ofs_x : ofs_y);

    ////////////////////////////////////////////////////////////////
    // drawing sequencer
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state <= PRDE_IDLE;
            cop_x <= 16'h0000; cop_y <= 16'h0000;
            bytes_left <= 16'h0000;
            word_buf <= 16'h0000;
            second_half <= 1'b0;
            cur_byte <= 8'h00;
            bit_idx <= 3'h7;
            seg_lo <= 16'h0000; seg_hi <= 16'h0000; seg_u <= 16'h0000; seg_v <= 16'h0000; seg_len <= 16'h0000;
            px <= 16'h0000; py <= 16'h0000;
            o_pix_we <= 1'b0;
            o_pix_x <= 16'h0000; o_pix_y <= 16'h0000;
            o_pix_value <= 8'h00; o_pix_mask <= 8'h00;
            o_data_ready <= 1'b0;
            o_busy <= 1'b0;
        end else begin
            o_pix_we <= 1'b0;
            o_data_ready <= 1'b0;
            case (state)
                PRDE_IDLE: begin
                    o_busy <= 1'b0;
                    if (go_pulse) begin
                        o_busy <= 1'b1;
                        o_pix_mask <= submask;
                        if (ctrl[CTRL_RASTER]) begin
                            bytes_left <= count[15:0];
                            second_half <= 1'b0;
                            px <= ctrl[CTRL_USE_START] ? st_x : (vert ? wx0 : wx0);
                            py <= ctrl[CTRL_USE_START] ? st_y : wy0;
                            state <= PRDE_RFETCH;
                        end else begin
                            bytes_left <= {count[15:1], 1'b0};
                            if (bl_on) begin
                                // start point sets only the along-axis position
                                if (vert) begin
                                    cop_x <= bl_abs;
                                    if (ctrl[CTRL_USE_START]) cop_y <= st_y;
                                end else begin
                                    cop_y <= bl_abs;
                                    if (ctrl[CTRL_USE_START]) cop_x <= st_x;
                                end
                            end else if (ctrl[CTRL_USE_START]) begin
                                cop_x <= st_x;
                                cop_y <= st_y;
                            end
                            state <= PRDE_FETCH;
                        end
                    end
                end
                PRDE_FETCH: begin
                    if (bytes_left == 16'h0000) begin
                        state <= PRDE_IDLE;
                    end else if (i_data_valid && o_data_ready) begin
                        // segment spans perpendicular between operating point and data; window not consulted
                        seg_lo <= (vert ? cop_x : cop_y) < data_abs ? (vert ? cop_x : cop_y) : data_abs;
                        seg_hi <= (vert ? cop_x : cop_y) < data_abs ? data_abs : (vert ? cop_x : cop_y);
                        seg_len <= vert ? dim[31:16] : dim[15:0];
                        seg_u <= (vert ? cop_x : cop_y) < data_abs ? (vert ? cop_x : cop_y) : data_abs;
                        seg_v <= 16'h0000;
                        bytes_left <= bytes_left - 16'h0002;
                        state <= PRDE_SEG;
                    end else begin
                        o_data_ready <= !o_data_ready;
                    end
                end
                PRDE_SEG: begin
                    if (seg_len == 16'h0000) begin
                        state <= PRDE_FETCH;
                    end else begin
                        o_pix_we <= 1'b1;
                        o_pix_value <= (bk ? bg : fg) & submask;
                        o_pix_x <= vert ? seg_u : cop_x + seg_v;
                        o_pix_y <= vert ? cop_y + seg_v : seg_u;
                        if (seg_u != seg_hi) begin
                            seg_u <= seg_u + 16'h0001;
                        end else if (seg_v + 16'h0001 != seg_len) begin
                            seg_u <= seg_lo;
                            seg_v <= seg_v + 16'h0001;
                        end else begin
                            if (vert) begin
                                cop_y <= cop_y + spacing[31:16];
                                if (bl_on) cop_x <= bl_abs;
                            end else begin
                                cop_x <= cop_x + spacing[15:0];
                                if (bl_on) cop_y <= bl_abs;
                            end
                            // linked mode leaves the perpendicular coordinate alone
                            state <= PRDE_FETCH;
                        end
                    end
                end
                PRDE_RFETCH: begin
                    if (bytes_left == 16'h0000) begin
                        cop_x <= px;
                        cop_y <= py;
                        state <= PRDE_IDLE;
                    end else if (second_half) begin
                        cur_byte <= ctrl[CTRL_ORDER] ? word_buf[15:8] : word_buf[7:0];
                        second_half <= 1'b0;
                        bit_idx <= 3'h7;
                        bytes_left <= bytes_left - 16'h0001;
                        state <= PRDE_RPIX;
                    end else if (i_data_valid && o_data_ready) begin
                        word_buf <= i_data;
                        cur_byte <= ctrl[CTRL_ORDER] ? i_data[7:0] : i_data[15:8];
                        second_half <= 1'b1;
                        bit_idx <= 3'h7;
                        bytes_left <= bytes_left - 16'h0001;
                        state <= PRDE_RPIX;
                    end else begin
                        o_data_ready <= !o_data_ready;
                    end
                end
                PRDE_RPIX: begin
                    if (bit_used(bit_idx, scale)) begin
                        // zero bit under no-write still steps the position
                        o_pix_we <= bit_val || !ctrl[CTRL_NOWR];
                        o_pix_value <= ((bit_val ^ bk) ? fg : bg) & submask;
                        o_pix_x <= px;
                        o_pix_y <= py;
                        if (at_prim_end) begin
                            if (vert) begin
                                py <= wy0;
                                px <= at_sec_end ? wx0 : px + 16'h0001;
                            end else begin
                                px <= wx0;
                                py <= at_sec_end ? wy0 : py + 16'h0001;
                            end
                        end else if (vert) begin
                            py <= py + 16'h0001;
                        end else begin
                            px <= px + 16'h0001;
                        end
                        if (byte_done) begin
                            state <= PRDE_RFETCH;
                        end
                    end else if (bit_idx == 3'h0) begin
                        state <= PRDE_RFETCH;
                    end
                    bit_idx <= bit_idx - 3'h1;
                end
                default: state <= PRDE_IDLE;
            endcase
        end
    end
endmodule

/* File: bench/prde_engine_props.sv */
// Purpose: port-level assertions for the plot/raster draw engine
// Assumes: single clock domain, synchronous active-high reset
// Notes: watches only top-level ports, attached by bind
`timescale 1ns/1ps
module prde_engine_props
    import prde_pkg::*;
(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // bus answers
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic o_rvalid,
    input wire logic i_rready,
    input wire logic [31:0] o_rdata,
    input wire logic [1:0] o_rresp,
    // stream and pixel port
    input wire logic o_data_ready,
    input wire logic o_pix_we,
    input wire logic [7:0] o_pix_value,
    input wire logic [7:0] o_pix_mask,
    input wire logic o_busy
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    a_reset_quiet: assert property ($fell(i_rst) |-> !o_pix_we && !o_busy && !o_data_ready)
        else $error("engine active right after reset");
    a_pix_masked: assert property (o_pix_we |-> (o_pix_value & ~o_pix_mask) == 8'h00)
        else $error("pixel value outside plane mask");
    a_ready_pulse: assert property (o_data_ready |=> !o_data_ready)
        else $error("data ready held two cycles");
    a_ready_busy: assert property (o_data_ready |-> o_busy)
        else $error("data ready while idle");
    a_write_busy: assert property (o_pix_we |-> o_busy)
        else $error("pixel write while idle");
    a_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid)
        else $error("write response dropped early");
    a_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp))
        else $error("read answer changed before taken");
    a_slverr_zero: assert property (o_rvalid && o_rresp == RESP_SLVERR |-> o_rdata == 32'h00000000)
        else $error("error read carries data");
endmodule
bind prde_engine prde_engine_props prde_engine_props_inst (.i_mclk(i_mclk), .i_rst(i_rst),
    .o_bvalid(o_bvalid), .i_bready(i_bready), .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
    .o_rresp(o_rresp), .o_data_ready(o_data_ready), .o_pix_we(o_pix_we), .o_pix_value(o_pix_value),
    .o_pix_mask(o_pix_mask), .o_busy(o_busy));

/* File: bench/prde_host_model.sv */
// Purpose: host side of the data word stream
// Assumes: words are queued by the bench through push
// Notes: an idle bus shows a changing pattern, the last word and its inverse in turn
`timescale 1ns/1ps
module prde_host_model (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // stream toward the engine
    input wire logic i_ready,
    output logic [15:0] o_data,
    output logic o_valid
);
    logic [15:0] q[$];
    int taken;
    initial begin
        o_valid = 1'b0;
        o_data = 16'h0000;
        taken = 0;
    end
    task push(input logic [15:0] w);
        q.push_back(w);
    endtask
    task flush;
        q.delete();
        taken = 0;
    endtask
    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_valid <= 1'b0;
        end else begin
            // word and valid hold until the edge that takes them
            if (o_valid && i_ready) begin
                void'(q.pop_front());
                taken <= taken + 1;
            end
            o_valid <= q.size() > 0;
            o_data <= (q.size() > 0) ? q[0] : ~o_data;
        end
    end
endmodule

/* File: bench/prde_engine_tb.sv */
// Purpose: self-checking bench for the plot/raster draw engine
// Assumes: AXI4-Lite register access, host stream from prde_host_model
// Notes: pixels are judged by count and coordinate sums, order free
`timescale 1ns/1ps
module prde_engine_tb import prde_pkg::*;;
    logic i_mclk, i_rst, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, pix_we, busy, data_ready, hvalid;
    logic [7:0] awaddr, araddr, pix_value, pix_mask, exp_val;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, strb;
    logic [1:0] bresp, rresp;
    logic [15:0] pix_x, pix_y, hdata;
    int num_errors = 0, checks = 0, npix, sx, sy;
    prde_engine prde_engine_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
        .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
        .i_data(hdata), .i_data_valid(hvalid), .o_data_ready(data_ready), .o_pix_we(pix_we), .o_pix_x(pix_x),
        .o_pix_y(pix_y), .o_pix_value(pix_value), .o_pix_mask(pix_mask), .o_busy(busy));
    prde_host_model prde_host_model_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_ready(data_ready),
        .o_data(hdata), .o_valid(hvalid));
    initial begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge i_mclk) begin
        if (pix_we === 1'b1) begin
            npix++;
            sx += pix_x;
            sy += pix_y;
            check(pix_value, exp_val, "pixel value");
            check(pix_mask, 8'h0F, "plane mask");
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // bus master; ready is raised late so the hold of each answer is exercised
    task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        int n;
        n = 0;
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= strb;
        wvalid <= 1'b1;
        do begin
            @(posedge i_mclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            bready <= bvalid;
        end while (!(bvalid && bready) && n < 200);
        resp = bresp;
        bready <= 1'b0;
        check(n < 200, 1, "write answer");
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge i_mclk);
            n++;
            if (arready) arvalid <= 1'b0;
            rready <= rvalid;
        end while (!(rvalid && rready) && n < 200);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        check(n < 200, 1, "read answer");
    endtask
    task run(input logic [31:0] ctrl);
        logic [1:0] r;
        int n;
        npix = 0;
        sx = 0;
        sy = 0;
        wr(OFF_CTRL, ctrl, r);
        n = 0;
        do begin
            @(posedge i_mclk);
            n++;
        end while ((busy !== 1'b0 || n < 3) && n < 5000);
        check(n < 5000, 1, "completion");
    endtask
    task judge(input int n, input int x, input int y, input int tk);
        check(npix, n, "pixel count");
        check(sx, x, "x sum");
        check(sy, y, "y sum");
        check(prde_host_model_inst.taken, tk, "words taken");
        prde_host_model_inst.flush();
        @(posedge i_mclk);
    endtask
    task opp(input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(OFF_OPPOINT, d, r);
        check(d, exp, "operating point");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_regs;
        logic [31:0] d;
        logic [1:0] r;
        rd(OFF_CTRL, d, r);
        check(d, RST_WORD, "ctrl reset");
        rd(OFF_STATUS, d, r);
        check(d, 32'h00000000, "status reset");
        rd(8'h40, d, r);
        check(r, RESP_SLVERR, "unmapped read");
        wr(8'h40, 32'h00000001, r);
        check(r, RESP_SLVERR, "unmapped write");
        wr(OFF_COLOR, 32'h000F335A, r);
        rd(OFF_COLOR, d, r);
        check(d, 32'h000F335A, "color readback");
        strb = 4'h1;
        wr(OFF_COLOR, 32'hFFFFFF5A, r);
        strb = 4'hF;
        rd(OFF_COLOR, d, r);
        check(d, 32'h000F335A, "byte strobes");
    endtask
    // baseline plot along y, odd count drops the third word, window left at reset
    task t_plot_base;
        logic [1:0] r;
        wr(OFF_BASELINE, 32'h0000000A, r);
        wr(OFF_DIM, 32'h00010002, r);
        wr(OFF_SPACING, 32'h00000003, r);
        wr(OFF_START, 32'h00000004, r);
        wr(OFF_COUNT, 32'h00000005, r);
        prde_host_model_inst.push(16'h000C);
        prde_host_model_inst.push(16'h0008);
        prde_host_model_inst.push(16'h0077);
        exp_val = 8'h0A;
        run(32'h00000021);
        judge(12, 72, 120, 2);
        opp(32'h000A000A);
    endtask
    // linked plot along x in background colour
    task t_plot_linked;
        logic [1:0] r;
        wr(OFF_BASELINE, 32'h00000000, r);
        wr(OFF_DIM, 32'h00010005, r);
        wr(OFF_SPACING, 32'h00020000, r);
        wr(OFF_START, 32'h00020005, r);
        wr(OFF_COUNT, 32'h00000004, r);
        prde_host_model_inst.push(16'h0007);
        prde_host_model_inst.push(16'h0006);
        prde_host_model_inst.push(16'h0055);
        exp_val = 8'h03;
        run(32'h00000425);
        judge(5, 29, 14, 2);
        opp(32'h00060005);
    endtask
    // raster, low byte first, zero bits skipped, 6-wide window drops two bits a row
    task t_raster;
        logic [1:0] r;
        wr(OFF_WIN_MIN, 32'h00000000, r);
        wr(OFF_WIN_MAX, 32'h00010005, r);
        wr(OFF_COUNT, 32'h00000003, r);
        prde_host_model_inst.push(16'hA5C3);
        prde_host_model_inst.push(16'h00FF);
        prde_host_model_inst.push(16'h1234);
        exp_val = 8'h0A;
        run(32'h0000001B);
        judge(11, 23, 3, 2);
    endtask
    // raster, high byte first, swapped colours, 1:2 scaling keeps four bits of one byte
    task t_raster_scaled;
        logic [1:0] r;
        wr(OFF_COUNT, 32'h00000001, r);
        prde_host_model_inst.push(16'hFF00);
        exp_val = 8'h03;
        run(32'h00004007);
        judge(4, 6, 0, 1);
    endtask
    initial begin
        i_rst = 1'b1;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h00000000;
        wstrb = 4'h0;
        strb = 4'hF;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        exp_val = 8'h00;
        repeat (5) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(posedge i_mclk);
        t_regs;
        t_plot_base;
        t_plot_linked;
        t_raster;
        t_raster_scaled;
        end_of_test;
    end
    initial begin
        #400000;
        num_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        end_of_test;
    end
endmodule
